// *** common/qscp_pkg.sv ***
// Package with constants and types for the queued serial control port
package qscp_pkg;

    localparam int unsigned QSCP_WORD_W = 8;
    localparam int unsigned QSCP_NUM_CS = 5;
    localparam int unsigned QSCP_NUM_PINS = 8;

    // Pin positions on the pin vectors
    localparam int unsigned QSCP_PIN_CS0 = 0;
    localparam int unsigned QSCP_PIN_SCK = 5;
    localparam int unsigned QSCP_PIN_MOSI = 6;
    localparam int unsigned QSCP_PIN_MISO = 7;

    // Index of the last of the 16 edges per word
    localparam logic [3:0] QSCP_LAST_EDGE = 4'h f;

    // Reset values
    localparam logic [7:0] QSCP_PIN_OUT_RST = 8'h00;
    localparam logic [7:0] QSCP_PIN_OE_N_RST = 8'hff;
    localparam logic [7:0] QSCP_WORD_RST = 8'h00;
    localparam logic [7:0] QSCP_CNT_RST = 8'h00;
    localparam logic [3:0] QSCP_EDGE_RST = 4'h0;

    typedef enum logic [2:0] {
        QSCP_ST_IDLE = 3'h0,
        QSCP_ST_LEAD = 3'h1,
        QSCP_ST_SHIFT = 3'h2,
        QSCP_ST_TRAIL = 3'h3,
        QSCP_ST_PUSH = 3'h4
    } qscp_state_e;

    typedef struct packed {
        logic [4:0] cs_active_high;
        logic [2:0] cs_index;
        logic [7:0] lead_cycles;
        logic [7:0] half_period;
        logic cpol;
        logic cpha;
        logic miso_fall;
        logic lsb_first;
    } qscp_cfg_s;

    localparam qscp_cfg_s QSCP_CFG_RST = '0;

endpackage

// *** src/qscp_buf.sv ***
// Two-entry receive buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module qscp_buf
    import qscp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [7:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    logic [7:0] ent_r [0:1];
    logic [1:0] vld_r;
    logic push;
    logic pop;

    assign in_ready = ~vld_r[1];
    assign push = in_valid & ~vld_r[1];
    assign pop = vld_r[0] & out_ready;
    assign out_data = ent_r[0];
    assign out_valid = vld_r[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            vld_r <= 2'h0;
        end else if (pop) begin
            vld_r[0] <= push | vld_r[1];
            vld_r[1] <= 1'b0;
        end else if (push) begin
            if (vld_r[0]) begin
                vld_r[1] <= 1'b1;
            end else begin
                vld_r[0] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ent_r[0] <= QSCP_WORD_RST;
            ent_r[1] <= QSCP_WORD_RST;
        end else if (pop) begin
            ent_r[0] <= push ? in_data : ent_r[1];
        end else if (push) begin
            if (vld_r[0]) begin
                ent_r[1] <= in_data;
            end else begin
                ent_r[0] <= in_data;
            end
        end
    end

endmodule
`default_nettype wire

// *** src/qscp_top.sv ***
// Queued serial control port: SPI master with per-pin general purpose fallback
`timescale 1ns/100ps
`default_nettype none
module qscp_top
    import qscp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire qscp_cfg_s cfg,
    input wire logic [7:0] func_en,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_dir_out,
    output logic [7:0] gpio_in,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic busy,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bit helpers

    function automatic logic out_bit(input logic [7:0] w, input logic lsb);
        out_bit = lsb ? w[0] : w[7];
    endfunction

    function automatic logic [7:0] shift_word(input logic [7:0] w, input logic b,
                                              input logic lsb);
        shift_word = lsb ? {b, w[7:1]} : {w[6:0], b};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    qscp_state_e state_r;
    qscp_state_e state_nxt;
    qscp_cfg_s cfg_r;
    logic [7:0] cnt_r;
    logic [3:0] edge_r;
    logic sck_r;
    logic mosi_r;
    logic cs_on_r;
    logic [7:0] tx_sh_r;
    logic [7:0] rx_sh_r;
    logic tx_ready_r;
    logic busy_r;
    logic [7:0] pin_out_r;
    logic [7:0] pin_oe_n_r;
    logic [7:0] gpio_in_r;
    logic accept;
    logic tick;
    logic sck_new;
    logic chg_edge;
    logic smp_edge;
    logic buf_in_ready;
    logic push;
    logic [7:0] drv_out;
    logic [7:0] drv_oe_n;

    assign accept = tx_valid & tx_ready_r;
    assign tick = (cnt_r >= cfg_r.half_period);
    assign sck_new = ~sck_r;
    // Change edges: trailing before the last for phase 0, leading after the first for phase 1
    assign chg_edge = cfg_r.cpha ? (~edge_r[0] & (edge_r != QSCP_EDGE_RST))
                                 : (edge_r[0] & (edge_r != QSCP_LAST_EDGE));
    assign smp_edge = (sck_new == ~cfg_r.miso_fall);
    assign push = (state_r == QSCP_ST_PUSH);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            QSCP_ST_IDLE: begin
                if (accept) begin
                    state_nxt = QSCP_ST_LEAD;
                end
            end
            QSCP_ST_LEAD: begin
                if (cnt_r >= cfg_r.lead_cycles) begin
                    state_nxt = QSCP_ST_SHIFT;
                end
            end
            QSCP_ST_SHIFT: begin
                if (tick && edge_r == QSCP_LAST_EDGE) begin
                    state_nxt = QSCP_ST_TRAIL;
                end
            end
            QSCP_ST_TRAIL: begin
                if (tick) begin
                    state_nxt = QSCP_ST_PUSH;
                end
            end
            QSCP_ST_PUSH: begin
                if (buf_in_ready) begin
                    state_nxt = QSCP_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= QSCP_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_ready_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            tx_ready_r <= (state_nxt == QSCP_ST_IDLE) && !accept;
            busy_r <= (state_nxt != QSCP_ST_IDLE);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r <= QSCP_CFG_RST;
        end else if (accept) begin
            cfg_r <= cfg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= QSCP_CNT_RST;
        end else if (state_r != state_nxt || (state_r == QSCP_ST_SHIFT && tick)) begin
            cnt_r <= QSCP_CNT_RST;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial clock and edge count

    always_ff @(posedge clk) begin
        if (rst) begin
            sck_r <= 1'b0;
            edge_r <= QSCP_EDGE_RST;
        end else if (accept) begin
            sck_r <= cfg.cpol;
            edge_r <= QSCP_EDGE_RST;
        end else if (state_r == QSCP_ST_SHIFT && tick) begin
            sck_r <= sck_new;
            edge_r <= edge_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Chip select hold

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_on_r <= 1'b0;
        end else if (accept) begin
            cs_on_r <= 1'b1;
        end else if (state_r == QSCP_ST_TRAIL && tick) begin
            cs_on_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit and receive shifters

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_sh_r <= QSCP_WORD_RST;
            mosi_r <= 1'b0;
        end else if (accept) begin
            tx_sh_r <= tx_data;
            mosi_r <= out_bit(tx_data, cfg.lsb_first);
        end else if (state_r == QSCP_ST_SHIFT && tick && chg_edge) begin
            tx_sh_r <= shift_word(tx_sh_r, 1'b0, cfg_r.lsb_first);
            mosi_r <= out_bit(shift_word(tx_sh_r, 1'b0, cfg_r.lsb_first),
                              cfg_r.lsb_first);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_sh_r <= QSCP_WORD_RST;
        end else if (state_r == QSCP_ST_SHIFT && tick && smp_edge) begin
            rx_sh_r <= shift_word(rx_sh_r, pin_in[QSCP_PIN_MISO], cfg_r.lsb_first);
        end
    end

    qscp_buf u_rx_buf (
        .clk(clk),
        .rst(rst),
        .in_data(rx_sh_r),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pin multiplexing

    always_comb begin
        drv_out = gpio_out;
        drv_oe_n = ~gpio_dir_out;
        for (int i = 0; i < QSCP_NUM_CS; i++) begin
            if (func_en[QSCP_PIN_CS0 + i]) begin
                drv_out[QSCP_PIN_CS0 + i] = (cs_on_r && cfg_r.cs_index == 3'(i))
                                            ~^ cfg.cs_active_high[i];
                drv_oe_n[QSCP_PIN_CS0 + i] = 1'b0;
            end
        end
        if (func_en[QSCP_PIN_SCK]) begin
            drv_out[QSCP_PIN_SCK] = busy_r ? sck_r : cfg.cpol;
            drv_oe_n[QSCP_PIN_SCK] = 1'b0;
        end
        if (func_en[QSCP_PIN_MOSI]) begin
            drv_out[QSCP_PIN_MOSI] = mosi_r;
            drv_oe_n[QSCP_PIN_MOSI] = 1'b0;
        end
        if (func_en[QSCP_PIN_MISO]) begin
            drv_out[QSCP_PIN_MISO] = 1'b0;
            drv_oe_n[QSCP_PIN_MISO] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out_r <= QSCP_PIN_OUT_RST;
            pin_oe_n_r <= QSCP_PIN_OE_N_RST;
            gpio_in_r <= QSCP_PIN_OUT_RST;
        end else begin
            pin_out_r <= drv_out;
            pin_oe_n_r <= drv_oe_n;
            gpio_in_r <= pin_in;
        end
    end

    assign tx_ready = tx_ready_r;
    assign busy = busy_r;
    assign pin_out = pin_out_r;
    assign pin_oe_n = pin_oe_n_r;
    assign gpio_in = gpio_in_r;

endmodule
`default_nettype wire

// *** test/qscp_sva.sv ***
// Assertion checker for the serial control port
`timescale 1ns/100ps
`default_nettype none
module qscp_sva
    import qscp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire qscp_cfg_s cfg,
    input wire logic [7:0] func_en,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_dir_out,
    input wire logic [7:0] gpio_in,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    qscp_cfg_s cfg_r;
    logic sck_r, cs_r, wait_r, cs_act, sck_edge;
    logic [9:0] cnt_r;
    logic [4:0] ecnt_r;
    assign cs_act = pin_out[cfg_r.cs_index] == cfg_r.cs_active_high[cfg_r.cs_index];
    assign sck_edge = pin_out[5] != sck_r;
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        cfg_r <= cfg;
        sck_r <= pin_out[5];
        cs_r <= cs_act;
        if (rst || (cs_act && !cs_r)) begin
            cnt_r <= 10'h001;
            wait_r <= !rst;
        end else if (wait_r) begin
            cnt_r <= cnt_r + 10'h001;
            wait_r <= !sck_edge;
        end
        if (tx_valid && tx_ready) begin
            ecnt_r <= 5'h00;
        end else if (cs_act && sck_edge && ecnt_r != 5'h1f) begin
            ecnt_r <= ecnt_r + 5'h01;
        end
    end
    ////////////////////////////////////////////////////////////////
    chk_rst_pins: assert property (disable iff (1'b0) rst |=> pin_oe_n == 8'hff && pin_out == 8'h00)
        else $error("pins not inputs after reset");
    chk_gpio_dir: assert property (func_en == 8'h00 |=> pin_oe_n == ~$past(gpio_dir_out)
        && ((pin_out ^ $past(gpio_out)) & $past(gpio_dir_out)) == 8'h00)
        else $error("gpio drive wrong");
    chk_gpio_in: assert property (!$past(rst) |-> gpio_in == $past(pin_in))
        else $error("gpio input wrong");
    chk_lead_gap: assert property (busy && $past(busy) && wait_r && sck_edge |->
        cnt_r == 10'(cfg_r.lead_cycles) + 10'(cfg_r.half_period) + 10'h002)
        else $error("select to clock gap wrong");
    chk_cs_hold: assert property (busy && $past(busy) && sck_edge |-> cs_act && $past(cs_act))
        else $error("clock edge without select");
    chk_unsel_cs: assert property ($past(func_en[4:0]) == 5'h1f |->
        ((pin_out[4:0] ^ cfg_r.cs_active_high) | (5'h01 << cfg_r.cs_index)) == 5'h1f)
        else $error("unselected select active");
    chk_edge_count: assert property ($fell(busy) |-> ecnt_r == 5'h10)
        else $error("clock edge count wrong");
    chk_func_oe: assert property ($past(func_en) == 8'hff |-> pin_oe_n == 8'h80)
        else $error("function pin direction wrong");
    cov_accept: cover property (tx_valid && tx_ready);
    cov_stall: cover property (rx_valid && !rx_ready);
    cov_done: cover property ($fell(busy));
endmodule
bind qscp_top qscp_sva u_sva (.clk, .rst, .cfg, .func_en, .gpio_out, .gpio_dir_out,
    .gpio_in, .pin_in, .pin_out, .pin_oe_n, .tx_valid, .tx_ready, .rx_valid, .rx_ready, .busy);
`default_nettype wire

// *** test/qscp_periph.sv ***
// Behavioural model of one serial peripheral
`timescale 1ns/100ps
`default_nettype none
module qscp_periph (
    input wire logic clk,
    input wire logic cs,
    input wire logic cs_hi,
    input wire logic sck,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic miso_fall,
    input wire logic lsb,
    input wire logic [7:0] resp,
    output logic miso,
    output logic [7:0] got
);
    logic sck_r;
    logic idle_r = 1'b0;
    logic [7:0] sh_r;
    logic act;
    assign act = cs === cs_hi;
    assign miso = act ? (lsb ? sh_r[0] : sh_r[7]) : idle_r;
    // Pins seen half a cycle after they change, as a real peripheral would
    always @(negedge clk) begin
        sck_r <= sck;
        idle_r <= ~idle_r;
        if (!act) begin
            sh_r <= resp;
        end else if (sck != sck_r && sck != miso_fall) begin
            sh_r <= lsb ? sh_r >> 1 : sh_r << 1;
        end
        if (act && sck != sck_r && ((sck != cpol) ^ cpha)) begin
            got <= lsb ? {mosi, got[7:1]} : {got[6:0], mosi};
        end
    end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Testbench for the serial control port
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import qscp_pkg::*;
;
    logic clk, rst, tx_valid, tx_ready, rx_valid, rx_ready, busy, miso, stall;
    qscp_cfg_s cfg;
    logic [7:0] func_en, gpio_out, gpio_dir_out, gpio_in, tx_data, rx_data;
    logic [7:0] pin_in, pin_out, pin_oe_n, prnd, resp, got, d, r;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int cmp_count = 0;
    int n;
    int seed = 32'he815;
    assign pin_in = (pin_oe_n & {miso, prnd[6:0]}) | (~pin_oe_n & pin_out);
    qscp_top u_dut (.clk, .rst, .cfg, .func_en, .gpio_out, .gpio_dir_out, .gpio_in, .tx_data,
        .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .busy, .pin_in, .pin_out, .pin_oe_n);
    qscp_periph u_per (.clk, .cs(pin_out[cfg.cs_index]), .cs_hi(cfg.cs_active_high[cfg.cs_index]),
        .sck(pin_out[5]), .mosi(pin_out[6]), .cpol(cfg.cpol), .cpha(cfg.cpha),
        .miso_fall(cfg.miso_fall), .lsb(cfg.lsb_first), .resp, .miso, .got);
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic conclude;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
    always @(posedge clk) begin
        rx_ready <= stall ? 1'b0 : 1'($random(seed));
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            chk(rx_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        end
    end
    initial begin
        rst <= 1'b1;
        stall <= 1'b0;
        tx_valid <= 1'b0;
        tx_data <= 8'h00;
        cfg <= '0;
        func_en <= 8'h00;
        gpio_out <= 8'h00;
        gpio_dir_out <= 8'h00;
        prnd <= 8'h00;
        resp <= 8'h00;
        tick(20);
        chk(pin_oe_n, 8'hff);
        rst <= 1'b0;
        repeat (40) begin
            @(posedge clk);
            gpio_out <= 8'($random(seed));
            gpio_dir_out <= 8'($random(seed));
            prnd <= 8'($random(seed));
        end
        tick(3);
        chk(pin_oe_n, ~gpio_dir_out);
        chk(gpio_in & 8'h7f, ((gpio_dir_out & gpio_out) | (~gpio_dir_out & prnd)) & 8'h7f);
        func_en <= 8'hff;
        tick(2);
        for (int i = 0; i < 20; i++) begin
            n = 0;
            while (i == 9 && rx_valid !== 1'b0 && n < 100) begin
                @(posedge clk);
                n++;
            end
            chk(8'(n >= 100), 8'h00);
            @(posedge clk);
            cfg <= '{5'($random(seed)), 3'(i % 5), i ? 8'($random(seed)) & 8'h07 : 8'h00,
                8'($random(seed)) & 8'h03, i[0], i[1], i[2], i[3]};
            r = 8'($random(seed));
            d = 8'($random(seed));
            resp <= r;
            exp_q.push_back(r);
            stall <= i inside {[9:11]};
            tx_data <= d;
            tx_valid <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (tx_ready !== 1'b1 && n < 500);
            tx_valid <= 1'b0;
            chk(8'(n >= 500), 8'h00);
            tick(2);
            if (i == 11) begin
                tick(200);
                chk({7'h00, busy}, 8'h01);
                chk({7'h00, tx_ready}, 8'h00);
                stall <= 1'b0;
            end
            n = 0;
            while (busy !== 1'b0 && n < 3000) begin
                @(posedge clk);
                n++;
            end
            chk(8'(n >= 3000), 8'h00);
            chk(got, d);
        end
        n = 0;
        while (exp_q.size() > 0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        tick(2);
        chk({7'h00, rx_valid}, 8'h00);
        chk(8'(exp_q.size()), 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
